// [hw/mac_transmit_control_status.v]
`timescale 1ns/1ps
`include "mac_tx_regs.vh"

module mac_transmit_control_status #(
  parameter             LEN_W       = 11,
  parameter             LVL_W       = 14,
  parameter             PTR_W       = 8,
  parameter [LVL_W-1:0] PAUSE_LEVEL = 14'h2000
) (
  input  wire             clock_i,
  input  wire             rst_i,
  input  wire [7:0]       reg_addr_i,
  input  wire [15:0]      reg_wdata_i,
  input  wire [1:0]       reg_be_i,
  input  wire             reg_wr_i,
  input  wire             reg_rd_i,
  output reg  [15:0]      reg_rdata_o,
  output reg              reg_rvalid_o,
  input  wire             frame_avail_i,
  input  wire [5:0]       frame_id_i,
  input  wire [LEN_W-1:0] frame_len_i,
  input  wire             frame_is_ip_i,
  input  wire             frame_is_tcp_i,
  input  wire             frame_is_icmp_i,
  input  wire             frame_fragment_i,
  input  wire             frame_done_i,
  input  wire             late_collision_i,
  input  wire             max_collision_i,
  input  wire             full_duplex_i,
  input  wire [LVL_W-1:0] rx_level_i,
  output wire             frame_start_o,
  output wire             frame_busy_o,
  output wire             engine_running_o,
  output wire             queue_flush_o,
  output wire [PTR_W-1:0] frame_ptr_o,
  output reg              ip_csum_insert_o,
  output reg              tcp_csum_insert_o,
  output reg              icmp_csum_insert_o,
  output reg              pad_insert_o,
  output reg  [LEN_W-1:0] pad_bytes_o,
  output reg              fcs_append_o,
  output wire             pause_send_o,
  output wire             backpressure_o
);

  localparam [LEN_W-1:0] MIN_LEN = `MIN_FRAME_BYTES;
  localparam [LEN_W-1:0] FCS_LEN = `FCS_BYTES;

  // Control register and its fields.
  reg  [15:0]      tx_ctrl_r;
  reg  [15:0]      tx_ctrl_nxt;
  wire             icmp_checksum_gen_en;
  wire             tcp_checksum_gen_en;
  wire             ip_header_checksum_gen_en;
  wire             transmit_queue_flush;
  wire             transmit_flow_control_en;
  wire             transmit_pad_en;
  wire             transmit_fcs_append_en;
  wire             transmit_run_en;

  // Status register fields and per-frame collision collectors.
  reg  [5:0]       sent_frame_tag;
  reg              late_collision_flag;
  reg              max_collision_flag;
  reg  [5:0]       cur_tag_r;
  reg              late_acc_r;
  reg              max_acc_r;
  wire [15:0]      tx_stat_w;

  // Frame length figures for padding.
  wire [LEN_W-1:0] wire_len_w;
  wire             short_w;

  // Register port decode.
  wire             ctrl_sel_w;
  wire             stat_sel_w;

  assign ctrl_sel_w = (reg_addr_i == `TX_CTRL_OFS);
  assign stat_sel_w = (reg_addr_i == `TX_STAT_OFS);

  // Field views of the control register.
  assign icmp_checksum_gen_en      = tx_ctrl_r[`CTL_ICMP_CSUM];
  assign tcp_checksum_gen_en       = tx_ctrl_r[`CTL_TCP_CSUM];
  assign ip_header_checksum_gen_en = tx_ctrl_r[`CTL_IP_CSUM];
  assign transmit_queue_flush      = tx_ctrl_r[`CTL_QFLUSH];
  assign transmit_flow_control_en  = tx_ctrl_r[`CTL_FLOW_EN];
  assign transmit_pad_en           = tx_ctrl_r[`CTL_PAD_EN];
  assign transmit_fcs_append_en    = tx_ctrl_r[`CTL_FCS_EN];
  assign transmit_run_en           = tx_ctrl_r[`CTL_RUN_EN];

  // Status word with reserved bits reading as zero.
  assign tx_stat_w = {2'h0,
                      late_collision_flag,
                      max_collision_flag,
                      6'h00,
                      sent_frame_tag};

  // Byte-lane write of the control register; reserved bits stay zero.
  always @* begin
    tx_ctrl_nxt = tx_ctrl_r;
    if (reg_wr_i && ctrl_sel_w) begin
      if (reg_be_i[0]) begin
        tx_ctrl_nxt[7:0] = reg_wdata_i[7:0];
      end
      if (reg_be_i[1]) begin
        tx_ctrl_nxt[15:8] = reg_wdata_i[15:8];
      end
    end
    tx_ctrl_nxt = tx_ctrl_nxt & `CTL_WR_MASK;
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      tx_ctrl_r <= `CTL_RST;
    end else begin
      tx_ctrl_r <= tx_ctrl_nxt;
    end
  end

  // Read answer one cycle after the strobe; unmapped offsets read zero.
  always @(posedge clock_i) begin
    if (rst_i) begin
      reg_rdata_o  <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        if (ctrl_sel_w) begin
          reg_rdata_o <= tx_ctrl_r;
        end else if (stat_sel_w) begin
          reg_rdata_o <= tx_stat_w;
        end else begin
          reg_rdata_o <= 16'h0000;
        end
      end
    end
  end

  // Run and stop of the engine, queue flush and frame pointer.
  tx_run_ctrl #(
    .PTR_W (PTR_W)
  ) u_run (
    .clock_i       (clock_i),
    .rst_i         (rst_i),
    .run_en_i      (transmit_run_en),
    .flush_i       (transmit_queue_flush),
    .frame_avail_i (frame_avail_i),
    .frame_done_i  (frame_done_i),
    .start_o       (frame_start_o),
    .busy_o        (frame_busy_o),
    .running_o     (engine_running_o),
    .flush_o       (queue_flush_o),
    .ptr_o         (frame_ptr_o)
  );

  // Pause frames or back-pressure from receive buffer fill.
  tx_flow_ctrl #(
    .LVL_W       (LVL_W),
    .PAUSE_LEVEL (PAUSE_LEVEL)
  ) u_flow (
    .clock_i        (clock_i),
    .rst_i          (rst_i),
    .flow_en_i      (transmit_flow_control_en),
    .full_duplex_i  (full_duplex_i),
    .level_i        (rx_level_i),
    .pause_send_o   (pause_send_o),
    .backpressure_o (backpressure_o)
  );

  // Length on the wire counts the check sequence when it is appended.
  assign wire_len_w = transmit_fcs_append_en ? (frame_len_i + FCS_LEN) : frame_len_i;
  assign short_w    = transmit_pad_en && (wire_len_w < MIN_LEN);

  // Per-frame insertion controls, captured as each frame starts.
  always @(posedge clock_i) begin
    if (rst_i) begin
      ip_csum_insert_o   <= 1'b0;
      tcp_csum_insert_o  <= 1'b0;
      icmp_csum_insert_o <= 1'b0;
      pad_insert_o       <= 1'b0;
      pad_bytes_o        <= {LEN_W{1'b0}};
      fcs_append_o       <= 1'b0;
    end else if (frame_start_o) begin
      ip_csum_insert_o   <= ip_header_checksum_gen_en && frame_is_ip_i;
      tcp_csum_insert_o  <= tcp_checksum_gen_en && frame_is_tcp_i;
      icmp_csum_insert_o <= icmp_checksum_gen_en && frame_is_icmp_i
                            && !frame_fragment_i;
      pad_insert_o       <= short_w;
      pad_bytes_o        <= short_w ? (MIN_LEN - wire_len_w) : {LEN_W{1'b0}};
      fcs_append_o       <= transmit_fcs_append_en;
    end
  end

  // Collisions gathered over the frame; an event on the start cycle is kept.
  always @(posedge clock_i) begin
    if (rst_i) begin
      cur_tag_r  <= 6'h00;
      late_acc_r <= 1'b0;
      max_acc_r  <= 1'b0;
    end else if (frame_start_o) begin
      cur_tag_r  <= frame_id_i;
      late_acc_r <= late_collision_i;
      max_acc_r  <= max_collision_i;
    end else begin
      late_acc_r <= late_acc_r | late_collision_i;
      max_acc_r  <= max_acc_r | max_collision_i;
    end
  end

  // Status fields replaced together at frame end, including that cycle's events.
  always @(posedge clock_i) begin
    if (rst_i) begin
      sent_frame_tag      <= 6'h00;
      late_collision_flag <= 1'b0;
      max_collision_flag  <= 1'b0;
    end else if (frame_done_i && frame_busy_o) begin
      sent_frame_tag      <= cur_tag_r;
      late_collision_flag <= late_acc_r | late_collision_i;
      max_collision_flag  <= max_acc_r | max_collision_i;
    end
  end

endmodule // mac_transmit_control_status

// [inc/mac_tx_regs.vh]
`ifndef MAC_TX_REGS_VH
`define MAC_TX_REGS_VH

// Register offsets on the register port.
`define TX_CTRL_OFS      8'h70
`define TX_STAT_OFS      8'h72

// Transmit control field positions.
`define CTL_ICMP_CSUM    8
`define CTL_TCP_CSUM     6
`define CTL_IP_CSUM      5
`define CTL_QFLUSH       4
`define CTL_FLOW_EN      3
`define CTL_PAD_EN       2
`define CTL_FCS_EN       1
`define CTL_RUN_EN       0
`define CTL_WR_MASK      16'h017F
`define CTL_RST          16'h0000

// Transmit status field positions.
`define STAT_LATE_COL    13
`define STAT_MAX_COL     12
`define STAT_TAG_MSB     5
`define STAT_TAG_LSB     0
`define STAT_RST         16'h0000

// Frame length figures in bytes.
`define MIN_FRAME_BYTES  64
`define FCS_BYTES        4

// Run control state codes.
`define RUN_ST_STOP      2'h0
`define RUN_ST_IDLE      2'h1
`define RUN_ST_SEND      2'h2
`define RUN_ST_DRAIN     2'h3

`endif

// [hw/tx_run_ctrl.v]
`timescale 1ns/1ps
`include "mac_tx_regs.vh"

module tx_run_ctrl #(
  parameter PTR_W = 8
) (
  input  wire             clock_i,
  input  wire             rst_i,
  input  wire             run_en_i,
  input  wire             flush_i,
  input  wire             frame_avail_i,
  input  wire             frame_done_i,
  output reg              start_o,
  output reg              busy_o,
  output reg              running_o,
  output reg              flush_o,
  output reg  [PTR_W-1:0] ptr_o
);

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg       start_nxt;

  // Next state of the engine; a frame in flight always runs to its end.
  always @* begin
    state_nxt = state_r;
    start_nxt = 1'b0;
    case (state_r)
      `RUN_ST_STOP: begin
        if (run_en_i && !flush_i) begin
          state_nxt = `RUN_ST_IDLE;
        end
      end
      `RUN_ST_IDLE: begin
        if (!run_en_i) begin
          state_nxt = `RUN_ST_STOP;
        end else if (frame_avail_i && !flush_i) begin
          state_nxt = `RUN_ST_SEND;
          start_nxt = 1'b1;
        end
      end
      `RUN_ST_SEND: begin
        if (frame_done_i) begin
          state_nxt = run_en_i ? `RUN_ST_IDLE : `RUN_ST_STOP;
        end else if (!run_en_i) begin
          state_nxt = `RUN_ST_DRAIN;
        end
      end
      `RUN_ST_DRAIN: begin
        if (frame_done_i) begin
          state_nxt = `RUN_ST_STOP;
        end else if (run_en_i) begin
          state_nxt = `RUN_ST_SEND;
        end
      end
      default: begin
        state_nxt = `RUN_ST_STOP;
      end
    endcase
  end

  // State, strobes and frame pointer.
  always @(posedge clock_i) begin
    if (rst_i) begin
      state_r   <= `RUN_ST_STOP;
      start_o   <= 1'b0;
      busy_o    <= 1'b0;
      running_o <= 1'b0;
      flush_o   <= 1'b0;
      ptr_o     <= {PTR_W{1'b0}};
    end else begin
      state_r   <= state_nxt;
      start_o   <= start_nxt;
      busy_o    <= (state_nxt == `RUN_ST_SEND) || (state_nxt == `RUN_ST_DRAIN);
      running_o <= (state_nxt == `RUN_ST_IDLE) || (state_nxt == `RUN_ST_SEND);
      flush_o   <= flush_i && (state_nxt == `RUN_ST_STOP);
      if (flush_i && (state_nxt == `RUN_ST_STOP)) begin
        ptr_o <= {PTR_W{1'b0}};
      end else if (frame_done_i && busy_o) begin
        ptr_o <= ptr_o + {{(PTR_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // tx_run_ctrl

// [hw/tx_flow_ctrl.v]
`timescale 1ns/1ps

module tx_flow_ctrl #(
  parameter             LVL_W       = 14,
  parameter [LVL_W-1:0] PAUSE_LEVEL = 14'h2000
) (
  input  wire             clock_i,
  input  wire             rst_i,
  input  wire             flow_en_i,
  input  wire             full_duplex_i,
  input  wire [LVL_W-1:0] level_i,
  output reg              pause_send_o,
  output reg              backpressure_o
);

  reg  sent_r;
  wire over_w;

  // Occupancy has reached the level that would lead to overflow.
  assign over_w = flow_en_i && (level_i >= PAUSE_LEVEL);

  // One pause request per crossing in full duplex, back-pressure level in half.
  always @(posedge clock_i) begin
    if (rst_i) begin
      sent_r         <= 1'b0;
      pause_send_o   <= 1'b0;
      backpressure_o <= 1'b0;
    end else begin
      pause_send_o   <= over_w && full_duplex_i && !sent_r;
      sent_r         <= over_w && full_duplex_i;
      backpressure_o <= over_w && !full_duplex_i;
    end
  end

endmodule // tx_flow_ctrl

// [tb/mac_tx_sva.sv]
`timescale 1ns/1ps
// Watches the block's ports for the timing of register answers, frames and flow control.
module mac_tx_sva #(
  parameter             LEN_W       = 11,
  parameter             LVL_W       = 14,
  parameter             PTR_W       = 8,
  parameter [LVL_W-1:0] PAUSE_LEVEL = 14'h2000
) (
  input wire             clock_i,
  input wire             rst_i,
  input wire             reg_rd_i,
  input wire             reg_rvalid_o,
  input wire             frame_start_o,
  input wire             frame_busy_o,
  input wire             frame_done_i,
  input wire [PTR_W-1:0] frame_ptr_o,
  input wire             queue_flush_o,
  input wire             engine_running_o,
  input wire             pause_send_o,
  input wire             backpressure_o,
  input wire             full_duplex_i,
  input wire [LVL_W-1:0] rx_level_i,
  input wire             frame_fragment_i,
  input wire             icmp_csum_insert_o,
  input wire [LEN_W-1:0] frame_len_i,
  input wire             pad_insert_o
);
  // Every check runs on the one clock and rests during reset.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  AST_RD_ANSWER: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read answer missing");
  AST_START_PULSE: assert property (frame_start_o |-> frame_busy_o ##1 !frame_start_o)
    else $error("start pulse wrong");
  AST_PTR_STEP: assert property (frame_busy_o && frame_done_i |=>
    frame_ptr_o == $past(frame_ptr_o) + 1'b1) else $error("pointer did not step");
  AST_FLUSH_STOP: assert property (queue_flush_o |->
    !engine_running_o && !frame_busy_o ##1 frame_ptr_o == '0) else $error("flush wrong");
  AST_PAUSE: assert property (pause_send_o |->
    $past(full_duplex_i && rx_level_i >= PAUSE_LEVEL) ##1 !pause_send_o)
    else $error("pause frame wrong");
  AST_BACKPRESSURE: assert property (backpressure_o |->
    $past(!full_duplex_i && rx_level_i >= PAUSE_LEVEL)) else $error("back-pressure wrong");
  AST_ICMP_FRAG: assert property (frame_start_o && frame_fragment_i |=>
    !icmp_csum_insert_o) else $error("fragment got icmp checksum");
  AST_NO_PAD: assert property (frame_start_o && frame_len_i >= 'h40 |=>
    !pad_insert_o) else $error("long frame padded");
endmodule // mac_tx_sva
bind mac_transmit_control_status mac_tx_sva #(.LEN_W(LEN_W), .LVL_W(LVL_W), .PTR_W(PTR_W),
  .PAUSE_LEVEL(PAUSE_LEVEL)) u_mac_tx_sva (.*);

// [tb/mac_far_model.sv]
`timescale 1ns/1ps
// Queue and MAC stand-in: offers a frame while asked, ends it after lat_i cycles.
module mac_far_model (
  input  wire       clock_i,
  input  wire       rst_i,
  input  wire       want_i,
  input  wire [7:0] lat_i,
  input  wire       lc_i,
  input  wire       mc_i,
  input  wire       frame_start_o,
  input  wire       frame_busy_o,
  output reg        frame_avail_i,
  output reg        frame_done_i,
  output reg        late_collision_i,
  output reg        max_collision_i
);
  reg [7:0] cnt_r;
  // Holds the offer until taken, then ends the frame with its collision events.
  always @(posedge clock_i) begin
    frame_done_i     <= 1'b0;
    late_collision_i <= 1'b0;
    max_collision_i  <= 1'b0;
    if (rst_i) begin
      frame_avail_i <= 1'b0;
      cnt_r         <= 8'h00;
    end else if (frame_start_o) begin
      frame_avail_i <= 1'b0;
      cnt_r         <= lat_i;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
      if (cnt_r == 8'h01) begin
        frame_done_i     <= 1'b1;
        late_collision_i <= lc_i;
        max_collision_i  <= mc_i;
      end
    end else begin
      frame_avail_i <= want_i & ~frame_busy_o;
    end
  end
endmodule // mac_far_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
`include "mac_tx_regs.vh"
module tb_top;
  reg         clock_i = 1'b0;
  reg         rst_i = 1'b1;
  reg  [7:0]  reg_addr_i = 8'h00;
  reg  [15:0] reg_wdata_i = 16'h0000;
  reg  [1:0]  reg_be_i = 2'h0;
  reg         reg_wr_i = 1'b0, reg_rd_i = 1'b0, want_i = 1'b0, lc_i = 1'b0, mc_i = 1'b0;
  reg  [5:0]  frame_id_i = 6'h00;
  reg  [10:0] frame_len_i = 11'h000;
  reg         frame_is_ip_i = 1'b0, frame_is_tcp_i = 1'b0, frame_is_icmp_i = 1'b0;
  reg         frame_fragment_i = 1'b0, full_duplex_i = 1'b0;
  reg  [13:0] rx_level_i = 14'h0000;
  reg  [7:0]  lat_i = 8'h04;
  wire [15:0] reg_rdata_o;
  wire [7:0]  frame_ptr_o;
  wire [10:0] pad_bytes_o;
  wire        reg_rvalid_o, frame_avail_i, frame_done_i, late_collision_i, max_collision_i;
  wire        frame_start_o, frame_busy_o, engine_running_o, queue_flush_o, fcs_append_o;
  wire        ip_csum_insert_o, tcp_csum_insert_o, icmp_csum_insert_o, pad_insert_o;
  wire        pause_send_o, backpressure_o;
  integer     num_errors = 0, checks_done = 0, n, pcnt = 0;
  reg  [15:0] rdat, pl;
  mac_transmit_control_status #(.PAUSE_LEVEL(14'h0100)) u_mac_transmit_control_status (.*);
  mac_far_model u_mac_far_model (.*);
  // The clock toggles every half period of 5 ns.
  initial forever #5 clock_i = ~clock_i;
  // Compares one value and counts it.
  task chk(input [8*6-1:0] what, input [15:0] exp, input [15:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // Register write: strobe for one cycle.
  task wr(input [7:0] a, input [15:0] d, input [1:0] b);
    begin
      @(posedge clock_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_be_i    <= b;
      reg_wr_i    <= 1'b1;
      @(posedge clock_i);
      reg_wr_i <= 1'b0;
    end
  endtask
  // Register read: the answer lands on the edge that takes the strobe.
  task rdc(input [7:0] a, input [15:0] e);
    begin
      @(posedge clock_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clock_i);
      reg_rd_i <= 1'b0;
      #1;
      rdat = reg_rdata_o;
      chk("rvalid", 16'h0001, reg_rvalid_o);
      chk("reg", e, rdat);
    end
  endtask
  // Waits a bounded time for a start pulse (k 0) or for the frame to end (k 1).
  task till(input k);
    begin
      n = 0;
      while ((k ? ~frame_busy_o : frame_start_o) !== 1'b1 && n < 60) begin
        @(posedge clock_i);
        #1;
        n = n + 1;
      end
      chk("wait", 1, n < 60);
    end
  endtask
  // Counts start pulses (k 1) or pause pulses (k 0) over ten cycles.
  task count(input k, input [15:0] exp);
    begin
      n = 0;
      repeat (10) begin
        @(posedge clock_i);
        #1;
        n = n + (k ? frame_start_o : pause_send_o);
      end
      chk("count", exp, n);
    end
  endtask
  // Sends one frame and checks what the engine made of it; stop clears run mid-frame.
  task frame(input [5:0] id, input [10:0] len, input [3:0] f, input [1:0] col,
             input [15:0] ctl, input stop);
    begin
      @(posedge clock_i);
      frame_id_i <= id;
      frame_len_i <= len;
      {frame_is_ip_i, frame_is_tcp_i, frame_is_icmp_i, frame_fragment_i} <= f;
      {lc_i, mc_i} <= col;
      lat_i <= stop ? 8'h1E : 8'h04;
      want_i <= 1'b1;
      till(0);
      @(posedge clock_i);
      want_i <= 1'b0;
      #1;
      pl = len + (ctl[1] ? `FCS_BYTES : 0);
      chk("ip", ctl[5] & f[3], ip_csum_insert_o);
      chk("tcp", ctl[6] & f[2], tcp_csum_insert_o);
      chk("icmp", ctl[8] & f[1] & ~f[0], icmp_csum_insert_o);
      chk("fcs", ctl[1], fcs_append_o);
      chk("pad", ctl[2] && pl < `MIN_FRAME_BYTES, pad_insert_o);
      if (ctl[2] && pl < `MIN_FRAME_BYTES)
        chk("padn", `MIN_FRAME_BYTES - pl, pad_bytes_o);
      if (stop) begin
        wr(`TX_CTRL_OFS, 16'h0000, 2'h3);
        repeat (2) @(posedge clock_i);
        #1;
        chk("run", 0, engine_running_o);
        chk("busy", 1, frame_busy_o);
      end
      till(1);
      pcnt = pcnt + 1;
      chk("ptr", pcnt, frame_ptr_o);
      rdc(`TX_STAT_OFS, {2'b00, col, 6'h00, id});
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task summarize;
    begin
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // Cuts a hang short well past the expected run length.
  initial begin
    #100000;
    num_errors = num_errors + 1;
    summarize;
  end
  // Main sequence of tests.
  initial begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    rdc(`TX_CTRL_OFS, 16'h0000);
    rdc(`TX_STAT_OFS, 16'h0000);
    wr(`TX_CTRL_OFS, 16'hFFEF, 2'h3);
    rdc(`TX_CTRL_OFS, 16'h016F);
    wr(`TX_CTRL_OFS, 16'h0000, 2'h1);
    rdc(`TX_CTRL_OFS, 16'h0100);
    wr(`TX_STAT_OFS, 16'hFFFF, 2'h3);
    rdc(`TX_STAT_OFS, 16'h0000);
    rdc(8'h7E, 16'h0000);
    $display("test registers done");
    wr(`TX_CTRL_OFS, 16'h0167, 2'h3);
    @(posedge clock_i);
    #1;
    chk("run", 1, engine_running_o);
    frame(6'h15, 11'h014, 4'hC, 2'h2, 16'h0167, 1'b0);
    frame(6'h2A, 11'h03C, 4'hA, 2'h1, 16'h0167, 1'b0);
    frame(6'h3F, 11'h03B, 4'hB, 2'h0, 16'h0167, 1'b0);
    wr(`TX_CTRL_OFS, 16'h0001, 2'h3);
    frame(6'h01, 11'h040, 4'hE, 2'h3, 16'h0001, 1'b0);
    frame(6'h22, 11'h01E, 4'h8, 2'h0, 16'h0001, 1'b1);
    $display("test frames done");
    @(posedge clock_i);
    want_i <= 1'b1;
    count(1, 0);
    wr(`TX_CTRL_OFS, 16'h0010, 2'h3);
    repeat (2) @(posedge clock_i);
    #1;
    chk("flush", 1, queue_flush_o);
    chk("ptr", 0, frame_ptr_o);
    count(1, 0);
    @(posedge clock_i);
    want_i <= 1'b0;
    wr(`TX_CTRL_OFS, 16'h0000, 2'h3);
    $display("test flush done");
    wr(`TX_CTRL_OFS, 16'h0008, 2'h3);
    full_duplex_i <= 1'b1;
    rx_level_i <= 14'h00FF;
    count(0, 0);
    @(posedge clock_i);
    rx_level_i <= 14'h0100;
    count(0, 1);
    chk("bp", 0, backpressure_o);
    @(posedge clock_i);
    full_duplex_i <= 1'b0;
    count(0, 0);
    chk("bp", 1, backpressure_o);
    wr(`TX_CTRL_OFS, 16'h0000, 2'h3);
    repeat (3) @(posedge clock_i);
    #1;
    chk("bp", 0, backpressure_o);
    @(posedge clock_i);
    full_duplex_i <= 1'b1;
    count(0, 0);
    $display("test flow done");
    summarize;
  end
endmodule // tb_top
